/* count_step.sv */
// one down-count step in binary or packed decimal
`timescale 1ns/1ps
module count_step
  import interval_timer_pkg::*;
(
  input wire logic [15:0] value_i,
  input wire logic decimal_i,
  input wire logic by_two_i,
  output logic [15:0] next_o
);
  logic [15:0] bin_one;
  logic [15:0] bin_two;
  logic [15:0] dec_one;
  logic [15:0] dec_two;

  // packed-decimal decrement with borrow across four digits
  function automatic logic [15:0] dec_sub1(input logic [15:0] v);
    logic [15:0] r;
    logic borrow;
    r = v;
    borrow = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      if (borrow)
      begin
        if (r[i*4 +: 4] == 4'h0)
        begin
          r[i*4 +: 4] = 4'h9;
        end
        else
        begin
          r[i*4 +: 4] = r[i*4 +: 4] - 4'h1;
          borrow = 1'b0;
        end
      end
    end
    dec_sub1 = r;
  endfunction : dec_sub1

  assign bin_one = value_i - 16'h0001;
  assign bin_two = value_i - 16'h0002;
  assign dec_one = dec_sub1(value_i);
  assign dec_two = dec_sub1(dec_one);
  assign next_o = decimal_i ? (by_two_i ? dec_two : dec_one)
                            : (by_two_i ? bin_two : bin_one);
endmodule : count_step

/* edge_sync.sv */
// three-flop capture of a counter clock with falling-edge pulse
`timescale 1ns/1ps
module edge_sync
  import interval_timer_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic sig_i,
  output logic fall_o
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end
    else if (ce_i)
    begin
      s1_q <= sig_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  assign fall_o = ce_i & s3_q & ~s2_q;
endmodule : edge_sync

/* host_model.sv */
// host processor model driving the timer's parallel port
`timescale 1ns/1ps
module host_model (
  input wire logic clk_sys_i,
  output logic select_n_o,
  output logic read_n_o,
  output logic write_n_o,
  output logic [1:0] register_select_o,
  output logic [7:0] data_o,
  input wire logic [7:0] data_i
);
  initial
  begin
    select_n_o = 1'b1;
    read_n_o = 1'b1;
    write_n_o = 1'b1;
    register_select_o = 2'h0;
    data_o = 8'h5a;
  end
  // a released data line shows the inverse of the last driven value
  task automatic wr(input logic [1:0] a, input logic [7:0] d, input logic sn = 1'b0);
    @(posedge clk_sys_i);
    #1 select_n_o = sn;
    register_select_o = a;
    data_o = d;
    write_n_o = 1'b0;
    repeat (3) @(posedge clk_sys_i);
    #1 write_n_o = 1'b1;
    @(posedge clk_sys_i);
    #1 select_n_o = 1'b1;
    data_o = ~d;
  endtask : wr
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk_sys_i);
    #1 select_n_o = 1'b0;
    register_select_o = a;
    read_n_o = 1'b0;
    repeat (3) @(posedge clk_sys_i);
    d = data_i;
    #1 read_n_o = 1'b1;
    @(posedge clk_sys_i);
    #1 select_n_o = 1'b1;
  endtask : rd
endmodule : host_model

/* interval_timer.sv */
// three-counter interval timer with 8-bit host port
// What this block does
// - 8-bit data bus driven only on reads
// - deselected: bus released, no register changes
// - select 0-2 counters, 3 control word
// - read select 3 or idle releases bus
// - control word field bit positions
// - counter select 11 is illegal
// - access format latch, low, high, both
// - mode decode ignores top bit modes 2,3
// - binary or four-digit packed decimal counting
// - control word clears counter, unreadable
// - zero count means 10000H counts, 10000 in decimal
// - mode 3 count one loads as zero, 10000H
// - mode 0 output low on control write
// - mode 0 counts after full count written
// - mode 0 output high at terminal count
// - low gate suspends counting, count held
// - one-byte rewrite halts, restarts next clock
// - three independent counters with own pins
// - mode 0 two-byte rewrite: low stops, high restarts
// - latch command freezes value for reading
// - decrement by one, by two in mode 3
`timescale 1ns/1ps
module interval_timer
  import interval_timer_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic select_n_i,
  input wire logic read_n_i,
  input wire logic write_n_i,
  input wire logic [1:0] register_select_i,
  input wire logic [7:0] host_data_bus_i,
  output logic [7:0] host_data_bus_o,
  output logic host_data_bus_oe_o,
  input wire logic [2:0] counter_clock_i,
  input wire logic [2:0] counter_gate_i,
  output logic [2:0] counter_output_o
);
  // host strobe edge detection (strobes sampled synchronously)
  logic read_n_q;
  logic write_n_q;
  wire access_en = ~select_n_i;
  // both strobes low at once is refused
  wire both_low = ~read_n_i & ~write_n_i;
  wire wr_edge = access_en & ~write_n_i & write_n_q & ~both_low;
  wire rd_edge = access_en & ~read_n_i & read_n_q & ~both_low;
  wire rd_active = access_en & ~read_n_i & write_n_i & (register_select_i != sel_control);

  // control word fields
  wire [1:0] cw_sel = host_data_bus_i[cw_counter_select_hi:cw_counter_select_lo];
  wire [1:0] cw_fmt = host_data_bus_i[cw_access_format_hi:cw_access_format_lo];
  wire [2:0] cw_mode = decode_mode(host_data_bus_i[cw_mode_hi:cw_mode_lo]);
  wire cw_dec = host_data_bus_i[cw_decimal_bit];
  wire cw_write = wr_edge & (register_select_i == sel_control);
  wire cw_legal = cw_sel != 2'h3;

  // per-counter state
  logic [15:0] count_q [num_counters];
  logic [15:0] reload_q [num_counters];
  logic [15:0] latch_q [num_counters];
  logic [2:0] latched_q;
  logic [1:0] fmt_q [num_counters];
  logic [2:0] mode_q [num_counters];
  logic [2:0] dec_q;
  logic [2:0] wr_ptr_q;
  logic [2:0] rd_ptr_q;
  logic [2:0] load_pend_q;
  logic [2:0] out_q;
  logic [2:0] readable_q;
  ctr_state_e state_q [num_counters];
  logic [7:0] rd_data_q;
  logic rd_oe_q;
  logic [7:0] rd_byte;
  logic [15:0] step_val [num_counters];
  logic [2:0] clk_fall;

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      read_n_q <= 1'b1;
      write_n_q <= 1'b1;
    end
    else if (ce_i)
    begin
      read_n_q <= read_n_i;
      write_n_q <= write_n_i;
    end
  end

  genvar g;
  generate
    for (g = 0; g < num_counters; g++)
    begin : gen_ctr
      wire sel_me = register_select_i == 2'(g);
      wire cw_me = cw_write & cw_legal & (cw_sel == 2'(g));
      wire cw_latch = cw_me & (cw_fmt == fmt_latch);
      wire cw_prog = cw_me & (cw_fmt != fmt_latch);
      wire cnt_wr = wr_edge & sel_me;
      // a write finishing the count: one-byte, or high byte of pair
      wire load_done = cnt_wr & ((fmt_q[g] != fmt_both) | wr_ptr_q[g]);
      wire low_of_pair = cnt_wr & (fmt_q[g] == fmt_both) & ~wr_ptr_q[g];
      wire is_m3 = mode_q[g] == mode_3;
      // gate as it stood when the synchronised clock sample was taken
      logic [1:0] gate_pipe_q;
      wire gate_at_edge = gate_pipe_q[1];
      wire tick = clk_fall[g] & gate_at_edge;
      wire at_tc = is_m3 ? (step_val[g] == 16'h0000 || count_q[g] == 16'h0001)
                         : (count_q[g] == 16'h0001);
      wire rd_me = rd_edge & sel_me;
      logic [15:0] next_reload;

      edge_sync u_clk_sync (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .sig_i(counter_clock_i[g]),
        .fall_o(clk_fall[g])
      );

      count_step u_step (
        .value_i(count_q[g]),
        .decimal_i(dec_q[g]),
        .by_two_i(is_m3),
        .next_o(step_val[g])
      );

      always_ff @(posedge clk_sys_i)
      begin
        if (rst_i)
        begin
          gate_pipe_q <= 2'h0;
        end
        else if (ce_i)
        begin
          gate_pipe_q <= {gate_pipe_q[0], counter_gate_i[g]};
        end
      end

      always_comb
      begin
        next_reload = reload_q[g];
        case (fmt_q[g])
          fmt_low: next_reload = {8'h00, host_data_bus_i};
          fmt_high: next_reload = {host_data_bus_i, 8'h00};
          fmt_both:
          begin
            if (wr_ptr_q[g])
            begin
              next_reload = {host_data_bus_i, reload_q[g][7:0]};
            end
            else
            begin
              next_reload = {reload_q[g][15:8], host_data_bus_i};
            end
          end
          default: next_reload = reload_q[g];
        endcase
      end

      always_ff @(posedge clk_sys_i)
      begin
        if (rst_i)
        begin
          fmt_q[g] <= fmt_both;
          mode_q[g] <= mode_0;
          dec_q[g] <= 1'b0;
          reload_q[g] <= count_reset;
          wr_ptr_q[g] <= 1'b0;
          load_pend_q[g] <= 1'b0;
        end
        else if (ce_i)
        begin
          if (cw_prog)
          begin
            fmt_q[g] <= cw_fmt;
            mode_q[g] <= cw_mode;
            dec_q[g] <= cw_dec;
            wr_ptr_q[g] <= 1'b0;
          end
          else if (cnt_wr && fmt_q[g] != fmt_latch)
          begin
            reload_q[g] <= next_reload;
            wr_ptr_q[g] <= (fmt_q[g] == fmt_both) ? ~wr_ptr_q[g] : 1'b0;
          end
          load_pend_q[g] <= load_done;
        end
      end

      // counting state machine
      always_ff @(posedge clk_sys_i)
      begin
        if (rst_i)
        begin
          state_q[g] <= ctr_idle;
          count_q[g] <= count_reset;
          out_q[g] <= 1'b0;
          readable_q[g] <= 1'b0;
        end
        else if (ce_i)
        begin
          if (cw_prog)
          begin
            state_q[g] <= ctr_idle;
            count_q[g] <= count_reset;
            readable_q[g] <= 1'b0;
            out_q[g] <= (cw_mode != mode_0);
          end
          else if (low_of_pair && mode_q[g] == mode_0)
          begin
            state_q[g] <= ctr_idle;
          end
          else if (load_done && mode_q[g] == mode_0)
          begin
            state_q[g] <= ctr_wait;
            out_q[g] <= 1'b0;
          end
          else if (load_pend_q[g])
          begin
            count_q[g] <= (is_m3 && reload_q[g] == 16'h0001) ? 16'h0000 : reload_q[g];
            readable_q[g] <= 1'b1;
            state_q[g] <= ctr_run;
          end
          else
          begin
            case (state_q[g])
              ctr_idle: state_q[g] <= ctr_idle;
              ctr_wait: state_q[g] <= ctr_wait;
              ctr_run:
              begin
                if (tick)
                begin
                  count_q[g] <= step_val[g];
                  if (at_tc && mode_q[g] == mode_0)
                  begin
                    out_q[g] <= 1'b1;
                  end
                end
              end
              default: state_q[g] <= ctr_idle;
            endcase
          end
        end
      end

      // latch and read pointer
      always_ff @(posedge clk_sys_i)
      begin
        if (rst_i)
        begin
          latch_q[g] <= count_reset;
          latched_q[g] <= 1'b0;
          rd_ptr_q[g] <= 1'b0;
        end
        else if (ce_i)
        begin
          if (cw_latch && !latched_q[g])
          begin
            latch_q[g] <= count_q[g];
            latched_q[g] <= 1'b1;
          end
          else if (rd_me && (fmt_q[g] != fmt_both || rd_ptr_q[g]))
          begin
            latched_q[g] <= 1'b0;
          end
          if (cw_prog)
          begin
            rd_ptr_q[g] <= 1'b0;
          end
          else if (rd_me && fmt_q[g] == fmt_both)
          begin
            rd_ptr_q[g] <= ~rd_ptr_q[g];
          end
        end
      end
    end
  endgenerate

  // what a read shows: the latch if held, the live count once loaded, else the reload
  function automatic logic [15:0] view_of(input logic held, input logic [15:0] latched,
      input logic live, input logic [15:0] count, input logic [15:0] reload);
    if (held)
    begin
      view_of = latched;
    end
    else if (live)
    begin
      view_of = count;
    end
    else
    begin
      view_of = reload;
    end
  endfunction : view_of

  // read data selection for the addressed counter
  logic [1:0] rs;
  logic [15:0] rd_word;
  logic rd_hi;
  always_comb
  begin
    rs = (register_select_i == sel_control) ? sel_counter0 : register_select_i;
    rd_word = view_of(latched_q[rs], latch_q[rs], readable_q[rs], count_q[rs], reload_q[rs]);
    case (fmt_q[rs])
      fmt_high: rd_hi = 1'b1;
      fmt_both: rd_hi = rd_ptr_q[rs];
      default: rd_hi = 1'b0;
    endcase
    rd_byte = rd_hi ? rd_word[15:8] : rd_word[7:0];
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      rd_data_q <= 8'h00;
      rd_oe_q <= 1'b0;
    end
    else if (ce_i)
    begin
      rd_oe_q <= rd_active;
      if (rd_edge)
      begin
        rd_data_q <= rd_byte;
      end
    end
  end

  assign host_data_bus_o = rd_data_q;
  assign host_data_bus_oe_o = rd_oe_q;
  assign counter_output_o = out_q;
endmodule : interval_timer

/* interval_timer_checker.sv */
// port assertions for the interval timer
`timescale 1ns/1ps
module interval_timer_checker
  import interval_timer_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic select_n_i,
  input wire logic read_n_i,
  input wire logic write_n_i,
  input wire logic [1:0] register_select_i,
  input wire logic [7:0] host_data_bus_i,
  input wire logic [7:0] host_data_bus_o,
  input wire logic host_data_bus_oe_o,
  input wire logic [2:0] counter_clock_i,
  input wire logic [2:0] counter_output_o
);
  logic clk0_q;
  logic [3:0] fall_age_q;
  logic [3:0] wr_age_q;
  // cycles since counter 0 clock fell and since the last selected write
  always_ff @(posedge clk_sys_i)
  begin
    clk0_q <= counter_clock_i[0];
    fall_age_q <= (rst_i || (clk0_q && !counter_clock_i[0])) ? 4'h0 : fall_age_q + 4'(fall_age_q != 4'hf);
    wr_age_q <= (rst_i || (!select_n_i && !write_n_i)) ? 4'h0 : wr_age_q + 4'(wr_age_q != 4'hf);
  end
  default clocking dc @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);
  chk_reset_idle: assert property (disable iff (1'b0) rst_i |=> !host_data_bus_oe_o)
    else $error("bus driven after reset");
  chk_desel_quiet: assert property (select_n_i |=> !host_data_bus_oe_o)
    else $error("bus driven while deselected");
  chk_oe_cause: assert property (host_data_bus_oe_o |-> $past(!read_n_i && !select_n_i))
    else $error("bus driven without a read");
  chk_read_answer: assert property ($fell(read_n_i) && !select_n_i && write_n_i
    && register_select_i != sel_control |=> host_data_bus_oe_o) else $error("read not answered");
  chk_ctl_no_oe: assert property ((!read_n_i && register_select_i == sel_control) [*2]
    |-> !host_data_bus_oe_o) else $error("control read drove the bus");
  chk_data_hold: assert property (host_data_bus_oe_o && $past(host_data_bus_oe_o)
    |-> $stable(host_data_bus_o)) else $error("read data changed mid read");
  chk_mode0_low: assert property ($fell(write_n_i) && !select_n_i && read_n_i
    && register_select_i == sel_control && host_data_bus_i[7:6] == 2'h0
    && host_data_bus_i[5:4] != fmt_latch
    && host_data_bus_i[3:1] == mode_0 |-> ##[1:4] !counter_output_o[0])
    else $error("mode 0 output not lowered");
  chk_rise_cause: assert property ($rose(counter_output_o[0]) |-> fall_age_q <= 4'h7
    || wr_age_q <= 4'h5) else $error("output rose without a cause");
  chk_fall_cause: assert property ($fell(counter_output_o[0]) |-> wr_age_q <= 4'h5)
    else $error("output fell without a write");
  cov_terminal: cover property ($rose(counter_output_o[0]));
  cov_read: cover property ($rose(host_data_bus_oe_o));
  cov_reprogram: cover property ($fell(counter_output_o[0]));
endmodule : interval_timer_checker

bind interval_timer interval_timer_checker interval_timer_checker_i (.clk_sys_i, .rst_i,
  .select_n_i, .read_n_i, .write_n_i, .register_select_i, .host_data_bus_i, .host_data_bus_o,
  .host_data_bus_oe_o, .counter_clock_i, .counter_output_o);

/* interval_timer_pkg.sv */
// shared constants and types for the three-counter interval timer
package interval_timer_pkg;
  localparam int unsigned num_counters = 3;
  localparam logic [1:0] sel_counter0 = 2'h0;
  localparam logic [1:0] sel_counter1 = 2'h1;
  localparam logic [1:0] sel_counter2 = 2'h2;
  localparam logic [1:0] sel_control = 2'h3;
  localparam int unsigned cw_counter_select_hi = 7;
  localparam int unsigned cw_counter_select_lo = 6;
  localparam int unsigned cw_access_format_hi = 5;
  localparam int unsigned cw_access_format_lo = 4;
  localparam int unsigned cw_mode_hi = 3;
  localparam int unsigned cw_mode_lo = 1;
  localparam int unsigned cw_decimal_bit = 0;
  localparam logic [1:0] fmt_latch = 2'h0;
  localparam logic [1:0] fmt_low = 2'h1;
  localparam logic [1:0] fmt_high = 2'h2;
  localparam logic [1:0] fmt_both = 2'h3;
  localparam logic [2:0] mode_0 = 3'h0;
  localparam logic [2:0] mode_1 = 3'h1;
  localparam logic [2:0] mode_2 = 3'h2;
  localparam logic [2:0] mode_3 = 3'h3;
  localparam logic [2:0] mode_4 = 3'h4;
  localparam logic [2:0] mode_5 = 3'h5;
  localparam logic [15:0] count_reset = 16'h0000;
  localparam logic [7:0] control_word_reset = 8'h00;

  typedef enum logic [2:0] {
    ctr_idle = 3'b001,
    ctr_wait = 3'b010,
    ctr_run = 3'b100
  } ctr_state_e;

  // normalise mode field: top bit ignored for modes 2 and 3
  function automatic logic [2:0] decode_mode(input logic [2:0] m);
    decode_mode = m[1] ? {1'b0, m[1:0]} : m;
  endfunction : decode_mode
endpackage : interval_timer_pkg

/* interval_timer_tb.sv */
// self-checking testbench for the interval timer
`timescale 1ns/1ps
module interval_timer_tb;
  logic clk_sys_i, rst_i, ce_i, select_n_i, read_n_i, write_n_i, host_data_bus_oe_o;
  logic [1:0] register_select_i;
  logic [7:0] host_data_bus_i, host_data_bus_o, host_d, got;
  logic [2:0] counter_clock_i, counter_gate_i, counter_output_o;
  logic [31:0] seed;
  int cnt[3], err_total, check_count, n, lat;
  bit run[3], out[3];
  assign host_data_bus_i = host_data_bus_oe_o ? host_data_bus_o : host_d;
  interval_timer interval_timer_i (.clk_sys_i, .rst_i, .ce_i, .select_n_i, .read_n_i,
    .write_n_i, .register_select_i, .host_data_bus_i, .host_data_bus_o, .host_data_bus_oe_o,
    .counter_clock_i, .counter_gate_i, .counter_output_o);
  host_model host_model_i (.clk_sys_i, .select_n_o(select_n_i), .read_n_o(read_n_i),
    .write_n_o(write_n_i), .register_select_o(register_select_i), .data_o(host_d),
    .data_i(host_data_bus_i));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e)
      $display("BAD %0t got %h want %h", $time, g, e);
    if (g !== e)
      err_total++;
  endtask : cmp
  task automatic rdc(input logic [1:0] a, input int e);
    host_model_i.rd(a, got);
    cmp(got, e[7:0]);
  endtask : rdc
  // k counter clock pulses, then the bench model follows
  task automatic tick(input int c, input int k);
    repeat (2 * k)
    begin
      repeat (10) @(posedge clk_sys_i);
      #1 counter_clock_i[c] = ~counter_clock_i[c];
    end
    repeat (10) @(posedge clk_sys_i);
    repeat (k)
    begin
      if (run[c] && counter_gate_i[c])
        cnt[c] = (cnt[c] + 65535) % 65536;
      if (run[c] && cnt[c] == 0)
        out[c] = 1'b1;
    end
  endtask : tick
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : wrap_up
  initial
  begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end
  initial
  begin
    rst_i = 1'b1;
    ce_i = 1'b1;
    counter_clock_i = 3'h0;
    counter_gate_i = 3'h7;
    seed = lfsr(32'hbe867c10);
    n = 2 + int'(seed[2:0]);
    repeat (3) @(posedge clk_sys_i);
    #1 rst_i = 1'b0;
    host_model_i.wr(2'h3, 8'h10);
    cmp(8'(counter_output_o[0]), 8'h0);
    host_model_i.wr(2'h0, 8'(n));
    cnt[0] = n;
    run[0] = 1'b1;
    tick(0, n - 1);
    cmp(8'(counter_output_o[0]), 8'(out[0]));
    rdc(2'h0, cnt[0]);
    tick(0, 3);
    cmp(8'(counter_output_o[0]), 8'(out[0]));
    rdc(2'h0, cnt[0]);
    $display("terminal count test done");
    host_model_i.wr(2'h3, 8'h10, 1'b1);
    cmp(8'(counter_output_o[0]), 8'(out[0]));
    rdc(2'h0, cnt[0]);
    $display("deselect test done");
    host_model_i.wr(2'h3, 8'h70);
    host_model_i.wr(2'h1, 8'h02);
    tick(1, 2);
    cmp(8'(counter_output_o[1]), 8'h0);
    host_model_i.wr(2'h1, 8'h01);
    cnt[1] = 'h0102;
    run[1] = 1'b1;
    counter_gate_i[1] = 1'b0;
    tick(1, 2);
    counter_gate_i[1] = 1'b1;
    tick(1, 2);
    rdc(2'h1, cnt[1]);
    rdc(2'h1, cnt[1] >> 8);
    $display("two byte and gate test done");
    lat = cnt[1];
    host_model_i.wr(2'h3, 8'h40);
    tick(1, 2);
    rdc(2'h1, lat);
    rdc(2'h1, lat >> 8);
    rdc(2'h1, cnt[1]);
    rdc(2'h1, cnt[1] >> 8);
    $display("latch test done");
    host_model_i.wr(2'h3, 8'h91);
    host_model_i.wr(2'h2, 8'h10);
    tick(2, 1);
    rdc(2'h2, 'h09);
    host_model_i.rd(2'h3, got);
    for (int m = 7; m >= 0; m--)
    begin
      host_model_i.wr(2'h3, {4'h1, 3'(m), 1'b0});
      cmp(8'(counter_output_o[0]), 8'(m != 0));
    end
    host_model_i.wr(2'h3, 8'hd2);
    cmp(8'(counter_output_o[0]), 8'h0);
    $display("decimal and mode test done");
    wrap_up();
  end
endmodule : interval_timer_tb
